// >>> logic/extended_interrupt_controller.sv
// Eleven-source vectored interrupt controller with two priority levels
`timescale 1ns/1ns
`include "eic_defines.svh"

module extended_interrupt_controller (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register access port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Legacy sources
   input wire logic ext0_req,
   input wire logic timer0_req,
   input wire logic ext1_req,
   input wire logic timer1_req,
   input wire logic serial_port_req,
   // Link and DMA status
   input wire logic dma_service,
   input wire logic tx_no_ack_flag,
   input wire logic tx_collision_flag,
   input wire logic tx_underrun_flag,
   input wire logic tx_fifo_not_full_flag,
   input wire logic tx_done_flag,
   input wire logic rx_crc_error_flag,
   input wire logic rx_overrun_flag,
   input wire logic rx_abort_flag,
   input wire logic alignment_error_flag,
   input wire logic rx_fifo_nonempty_flag,
   input wire logic rx_done_flag,
   input wire logic dma0_done,
   input wire logic dma1_done,
   // CPU service side
   output logic irq_request,
   output logic [7:0] irq_vector,
   output logic irq_level_high,
   input wire logic irq_ack,
   input wire logic irq_return
);
   localparam int N = `NUM_SOURCES;

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] legacy_interrupt_enable;
   logic [7:0] legacy_interrupt_priority;
   logic [5:0] extended_interrupt_enable;
   logic [5:0] extended_interrupt_priority;
   logic in_service_high;
   logic in_service_low;
   eic_pkg::req_state_type state;
   eic_pkg::req_state_type next_state;

   wire wr_leg_en = sfr_wr && (sfr_addr == `ADDR_LEGACY_EN);
   wire wr_leg_pri = sfr_wr && (sfr_addr == `ADDR_LEGACY_PRI);
   wire wr_ext_en = sfr_wr && (sfr_addr == `ADDR_EXT_EN);
   wire wr_ext_pri = sfr_wr && (sfr_addr == `ADDR_EXT_PRI);

   // Reserved bits are not stored and read back as zero
   wire [7:0] read_mux =
      (sfr_addr == `ADDR_LEGACY_EN) ? (legacy_interrupt_enable & `LEGACY_EN_MASK) :
      (sfr_addr == `ADDR_LEGACY_PRI) ? (legacy_interrupt_priority & `LEGACY_PRI_MASK) :
      (sfr_addr == `ADDR_EXT_EN) ? {2'h0, extended_interrupt_enable} :
      (sfr_addr == `ADDR_EXT_PRI) ? {2'h0, extended_interrupt_priority} :
      `READ_UNMAPPED;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         legacy_interrupt_enable <= `RESET_BYTE;
         legacy_interrupt_priority <= `RESET_BYTE;
         extended_interrupt_enable <= 6'(`RESET_BYTE);
         extended_interrupt_priority <= 6'(`RESET_BYTE);
         sfr_rdata <= `RESET_BYTE;
      end else begin
         if (wr_leg_en)
            legacy_interrupt_enable <= sfr_wdata & `LEGACY_EN_MASK;
         if (wr_leg_pri)
            legacy_interrupt_priority <= sfr_wdata & `LEGACY_PRI_MASK;
         if (wr_ext_en)
            extended_interrupt_enable <= sfr_wdata[5:0];
         if (wr_ext_pri)
            extended_interrupt_priority <= sfr_wdata[5:0];
         if (sfr_rd)
            sfr_rdata <= read_mux;
      end
   end

   // ****************************************
   // Source conditions
   // ****************************************
   wire src_txe = dma_service ?
      (tx_no_ack_flag | tx_collision_flag | tx_underrun_flag) :
      (tx_no_ack_flag | tx_collision_flag);
   wire src_txv = dma_service ? tx_done_flag : tx_fifo_not_full_flag;
   wire src_rxe = rx_crc_error_flag | rx_overrun_flag | rx_abort_flag
      | alignment_error_flag;
   wire src_rxv = dma_service ? rx_done_flag : rx_fifo_nonempty_flag;

   // Raw sources, enables and priorities laid out in polling order
   wire [N-1:0] raw = {serial_port_req, src_txe, timer1_req, dma1_done, src_txv,
      ext1_req, dma0_done, src_rxe, timer0_req, src_rxv, ext0_req};
   wire [5:0] xe = extended_interrupt_enable;
   wire [5:0] xp = extended_interrupt_priority;
   wire [7:0] le = legacy_interrupt_enable;
   wire [7:0] lp = legacy_interrupt_priority;
   wire [N-1:0] en = {le[`LEG_SERIAL_BIT], xe[`EXT_TXE_BIT], le[`LEG_TIMER1_BIT],
      xe[`EXT_DMA1_BIT], xe[`EXT_TXV_BIT], le[`LEG_EXT1_BIT], xe[`EXT_DMA0_BIT],
      xe[`EXT_RXE_BIT], le[`LEG_TIMER0_BIT], xe[`EXT_RXV_BIT], le[`LEG_EXT0_BIT]};
   wire [N-1:0] pri = {lp[`LEG_SERIAL_BIT], xp[`EXT_TXE_BIT], lp[`LEG_TIMER1_BIT],
      xp[`EXT_DMA1_BIT], xp[`EXT_TXV_BIT], lp[`LEG_EXT1_BIT], xp[`EXT_DMA0_BIT],
      xp[`EXT_RXE_BIT], lp[`LEG_TIMER0_BIT], xp[`EXT_RXV_BIT], lp[`LEG_EXT0_BIT]};

   // ****************************************
   // Arbitration
   // ****************************************
   wire global_en = le[`GLOBAL_EN_BIT];
   wire [N-1:0] pending = raw & en & {N{global_en}};
   wire [N-1:0] high_req = pending & pri & {N{!in_service_high}};
   wire [N-1:0] low_req = pending & ~pri & {N{!in_service_high && !in_service_low}};
   logic high_valid;
   logic low_valid;
   logic [3:0] high_idx;
   logic [3:0] low_idx;

   poll_picker #(.N(N), .W(4)) u_high (.req(high_req), .valid(high_valid), .idx(high_idx));
   poll_picker #(.N(N), .W(4)) u_low (.req(low_req), .valid(low_valid), .idx(low_idx));

   function automatic logic [7:0] vector_of(input logic [3:0] idx);
      case (idx)
         `POLL_EXT0: vector_of = `VEC_EXT0;
         `POLL_RXV: vector_of = `VEC_RXV;
         `POLL_TIMER0: vector_of = `VEC_TIMER0;
         `POLL_RXE: vector_of = `VEC_RXE;
         `POLL_DMA0: vector_of = `VEC_DMA0;
         `POLL_EXT1: vector_of = `VEC_EXT1;
         `POLL_TXV: vector_of = `VEC_TXV;
         `POLL_DMA1: vector_of = `VEC_DMA1;
         `POLL_TIMER1: vector_of = `VEC_TIMER1;
         `POLL_TXE: vector_of = `VEC_TXE;
         `POLL_SERIAL: vector_of = `VEC_SERIAL;
         default: vector_of = `VEC_EXT0;
      endcase
   endfunction

   wire win_valid = high_valid || low_valid;
   wire win_high = high_valid;
   wire [7:0] win_vector = vector_of(high_valid ? high_idx : low_idx);

   // Request only while the registered vector still names the current winner
   assign irq_request = (state == eic_pkg::ST_REQUEST) && win_valid
      && (win_vector == irq_vector) && (win_high == irq_level_high);
   wire taken = irq_request && irq_ack;

   always_comb begin
      next_state = state;
      case (state)
         eic_pkg::ST_IDLE: begin
            if (win_valid)
               next_state = eic_pkg::ST_REQUEST;
         end
         eic_pkg::ST_REQUEST: begin
            if (taken || !win_valid)
               next_state = eic_pkg::ST_IDLE;
         end
         default: next_state = eic_pkg::ST_IDLE;
      endcase
   end

   // A return ends the highest active level; a new entry in the same cycle wins
   wire ret_high = irq_return && in_service_high;
   wire ret_low = irq_return && !in_service_high;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= eic_pkg::ST_IDLE;
         irq_vector <= `RESET_BYTE;
         irq_level_high <= 1'b0;
         in_service_high <= 1'b0;
         in_service_low <= 1'b0;
      end else begin
         state <= next_state;
         irq_vector <= win_vector;
         irq_level_high <= win_high;
         if (taken && irq_level_high)
            in_service_high <= 1'b1;
         else if (ret_high)
            in_service_high <= 1'b0;
         if (taken && !irq_level_high)
            in_service_low <= 1'b1;
         else if (ret_low)
            in_service_low <= 1'b0;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_ext_reserved;
      sfr_rd && sfr_addr == `ADDR_EXT_EN |=> sfr_rdata[7:6] == 2'h0;
   endproperty
   a_ext_reserved: assert property (p_ext_reserved) else $error("reserved bits not zero");

   // Write, one idle cycle, then a read of the same register
   property p_ext_write;
      wr_ext_en ##1 !sfr_wr ##1 (sfr_rd && sfr_addr == `ADDR_EXT_EN && !sfr_wr)
         |=> sfr_rdata[5:0] == $past(sfr_wdata[5:0], 3);
   endproperty
   a_ext_write: assert property (p_ext_write) else $error("enable write lost");

   property p_txe_cpu;
      !dma_service && tx_underrun_flag && !tx_no_ack_flag && !tx_collision_flag
         |-> !pending[`POLL_TXE];
   endproperty
   a_txe_cpu: assert property (p_txe_cpu) else $error("underrun raised in cpu mode");

   property p_txe_dma;
      dma_service && tx_underrun_flag && global_en && xe[`EXT_TXE_BIT]
         |-> pending[`POLL_TXE];
   endproperty
   a_txe_dma: assert property (p_txe_dma) else $error("underrun missed in dma mode");

   property p_rxv_mode;
      global_en && xe[`EXT_RXV_BIT] |->
         pending[`POLL_RXV] == (dma_service ? rx_done_flag : rx_fifo_nonempty_flag);
   endproperty
   a_rxv_mode: assert property (p_rxv_mode) else $error("rx valid source wrong");

   property p_gated;
      irq_request |-> global_en && (pending != '0) && $past(win_valid);
   endproperty
   a_gated: assert property (p_gated) else $error("request while disabled");

   property p_no_preempt;
      in_service_high |-> !irq_request;
   endproperty
   a_no_preempt: assert property (p_no_preempt) else $error("high routine preempted");

   property p_low_preempt;
      in_service_low && irq_request |-> irq_level_high;
   endproperty
   a_low_preempt: assert property (p_low_preempt) else $error("equal level preempted");

   property p_first_poll;
      irq_request && !irq_level_high && pending[`POLL_EXT0] |-> irq_vector == `VEC_EXT0;
   endproperty
   a_first_poll: assert property (p_first_poll) else $error("polling order broken");

   property p_high_wins;
      irq_request && (pending & pri) != '0 |-> irq_level_high;
   endproperty
   a_high_wins: assert property (p_high_wins) else $error("low level beat high");

   property p_req_follows;
      state == eic_pkg::ST_IDLE && win_valid && !in_service_high ##1 win_valid && $stable(pending)
         && $stable(in_service_low) |-> irq_request;
   endproperty
   a_req_follows: assert property (p_req_follows) else $error("request not raised");

   c_taken_low: cover property (taken && !irq_level_high);
   c_preempt: cover property (in_service_low && taken && irq_level_high);
   c_dma_txe: cover property (irq_request && dma_service && irq_vector == `VEC_TXE);
   c_return: cover property (in_service_high ##1 irq_return);
endmodule

// >>> logic/eic_defines.svh
// Register addresses, field positions, reset values and vectors of the interrupt controller
`ifndef EIC_DEFINES_SVH
`define EIC_DEFINES_SVH

// ****************************************
// Direct register addresses
// ****************************************
`define ADDR_LEGACY_EN 8'hA8
`define ADDR_LEGACY_PRI 8'hB8
`define ADDR_EXT_EN 8'hC8
`define ADDR_EXT_PRI 8'hF8

// ****************************************
// Reset values and implemented bits
// ****************************************
`define RESET_BYTE 8'h00
`define LEGACY_EN_MASK 8'h9F
`define LEGACY_PRI_MASK 8'h1F
`define EXT_MASK 8'h3F
`define READ_UNMAPPED 8'h00

// ****************************************
// Field positions
// ****************************************
`define GLOBAL_EN_BIT 7
`define LEG_EXT0_BIT 0
`define LEG_TIMER0_BIT 1
`define LEG_EXT1_BIT 2
`define LEG_TIMER1_BIT 3
`define LEG_SERIAL_BIT 4
`define EXT_RXV_BIT 0
`define EXT_RXE_BIT 1
`define EXT_DMA0_BIT 2
`define EXT_TXV_BIT 3
`define EXT_DMA1_BIT 4
`define EXT_TXE_BIT 5

// ****************************************
// Polling positions and vectors
// ****************************************
`define NUM_SOURCES 11
`define POLL_EXT0 4'h0
`define POLL_RXV 4'h1
`define POLL_TIMER0 4'h2
`define POLL_RXE 4'h3
`define POLL_DMA0 4'h4
`define POLL_EXT1 4'h5
`define POLL_TXV 4'h6
`define POLL_DMA1 4'h7
`define POLL_TIMER1 4'h8
`define POLL_TXE 4'h9
`define POLL_SERIAL 4'hA
`define VEC_EXT0 8'h03
`define VEC_RXV 8'h2B
`define VEC_TIMER0 8'h0B
`define VEC_RXE 8'h33
`define VEC_DMA0 8'h3B
`define VEC_EXT1 8'h13
`define VEC_TXV 8'h43
`define VEC_DMA1 8'h53
`define VEC_TIMER1 8'h1B
`define VEC_TXE 8'h4B
`define VEC_SERIAL 8'h23

`endif

// >>> logic/eic_pkg.sv
// Types shared by the interrupt controller files
package eic_pkg;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_REQUEST = 1'b1
   } req_state_type;
endpackage

// >>> logic/poll_picker.sv
// Picks the first set request in polling order
`timescale 1ns/1ns
module poll_picker #(
   parameter int N = 11,
   parameter int W = 4
) (
   // Requests, bit 0 polled first
   input wire logic [N-1:0] req,
   // Result
   output logic valid,
   output logic [W-1:0] idx
);
   generate
      if (N < 1 || N > (1 << W)) begin : g_check
         $error("poll_picker: N does not fit the index width");
      end
   endgenerate

   always_comb begin
      valid = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            valid = 1'b1;
            idx = W'(i);
         end
      end
   end
endmodule

// >>> verification/cpu_model.sv
// Behavioural CPU core that takes vectored interrupts
`timescale 1ns/1ns
module cpu_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Bench control and record of taken vectors
   input wire logic en,
   input wire logic [1:0] dly,
   input wire logic do_ret,
   output logic [7:0] n_taken,
   output logic [7:0] taken_vec,
   output logic taken_high,
   // Interrupt port
   input wire logic irq_request,
   input wire logic [7:0] irq_vector,
   input wire logic irq_level_high,
   output logic irq_ack,
   output logic irq_return
);
   logic [1:0] wait_cnt;
   // ****************************************
   // Ack after dly cycles; vector counts only if request still stands
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_ack <= 1'b0;
         irq_return <= 1'b0;
         n_taken <= 8'h00;
         taken_vec <= 8'h00;
         taken_high <= 1'b0;
         wait_cnt <= 2'h0;
      end else begin
         irq_return <= do_ret;
         irq_ack <= 1'b0;
         if (irq_ack) begin
            wait_cnt <= 2'h0;
            if (irq_request) begin
               n_taken <= n_taken + 8'h01;
               taken_vec <= irq_vector;
               taken_high <= irq_level_high;
            end
         end else if (en && irq_request) begin
            if (wait_cnt == dly) begin
               irq_ack <= 1'b1;
            end else begin
               wait_cnt <= wait_cnt + 2'h1;
            end
         end
      end
   end
endmodule

// >>> verification/extended_interrupt_controller_tb.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/1ns
`define CHK(a, e, msg) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %0t %s", $time, msg); end end
module extended_interrupt_controller_tb;
   logic clk, rstn, sfr_wr, sfr_rd, dma_service, en, do_ret, ack, ret, ga;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, irq_vector, n_taken, taken_vec, d, v, k;
   logic irq_request, irq_level_high, taken_high;
   logic [10:0] f, m, p;
   logic [4:0] leg;
   logic [1:0] dmad, dly;
   logic [5:0] e;
   logic [31:0] s;
   int n_fail, samples_checked;
   logic [7:0] vt [0:10] = '{8'h03, 8'h2B, 8'h0B, 8'h33, 8'h3B, 8'h13, 8'h43, 8'h53, 8'h1B,
      8'h4B, 8'h23};
   logic [7:0] ra [0:3] = '{8'hA8, 8'hB8, 8'hC8, 8'hF8};
   logic [7:0] rm [0:3] = '{8'h9F, 8'h1F, 8'h3F, 8'h3F};
   extended_interrupt_controller uut (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .ext0_req(leg[0]), .timer0_req(leg[1]), .ext1_req(leg[2]), .timer1_req(leg[3]),
      .serial_port_req(leg[4]), .dma_service(dma_service), .tx_no_ack_flag(f[0]),
      .tx_collision_flag(f[1]), .tx_underrun_flag(f[2]), .tx_fifo_not_full_flag(f[3]),
      .tx_done_flag(f[4]), .rx_crc_error_flag(f[5]), .rx_overrun_flag(f[6]),
      .rx_abort_flag(f[7]), .alignment_error_flag(f[8]), .rx_fifo_nonempty_flag(f[9]),
      .rx_done_flag(f[10]), .dma0_done(dmad[0]), .dma1_done(dmad[1]),
      .irq_request(irq_request), .irq_vector(irq_vector), .irq_level_high(irq_level_high),
      .irq_ack(ack), .irq_return(ret));
   cpu_model cpu (.clk(clk), .rstn(rstn), .en(en), .dly(dly), .do_ret(do_ret),
      .n_taken(n_taken), .taken_vec(taken_vec), .taken_high(taken_high),
      .irq_request(irq_request), .irq_vector(irq_vector), .irq_level_high(irq_level_high),
      .irq_ack(ack), .irq_return(ret));
   // ****************************************
   // Expectation functions, sources in polling order
   // ****************************************
   function logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function logic [10:0] raw_src(input logic md, input logic [10:0] fl, input logic [4:0] lg,
      input logic [1:0] dd);
      return {lg[4], fl[0] | fl[1] | (md & fl[2]), lg[3], dd[1], md ? fl[4] : fl[3], lg[2],
         dd[0], |fl[8:5], lg[1], md ? fl[10] : fl[9], lg[0]};
   endfunction
   function logic [5:0] pick(input logic [10:0] r, input logic [10:0] pr);
      logic [10:0] h;
      logic [3:0] i;
      h = ((r & pr) != 11'h000) ? (r & pr) : r;
      i = 4'h0;
      for (int j = 10; j >= 0; j--) if (h[j]) i = j[3:0];
      return {h != 11'h000, (r & pr) != 11'h000, i};
   endfunction
   // ****************************************
   // Register port and service tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge clk) begin
         sfr_addr <= a;
         sfr_wdata <= w;
         sfr_wr <= 1'b1;
      end
      @(posedge clk) sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(posedge clk) begin
         sfr_addr <= a;
         sfr_rd <= 1'b1;
      end
      @(posedge clk) sfr_rd <= 1'b0;
      #1 r = sfr_rdata;
   endtask
   task automatic set_regs(input logic g, input logic [10:0] mk, input logic [10:0] pk);
      wr(8'hB8, {3'h0, pk[10], pk[8], pk[5], pk[2], pk[0]});
      wr(8'hF8, {2'h0, pk[9], pk[7], pk[6], pk[4], pk[3], pk[1]});
      wr(8'hC8, {2'h0, mk[9], mk[7], mk[6], mk[4], mk[3], mk[1]});
      wr(8'hA8, {g, 2'h0, mk[10], mk[8], mk[5], mk[2], mk[0]});
   endtask
   task automatic take(input logic [7:0] vec, input logic hi);
      k = k + 8'h01;
      for (int c = 0; c < 60 && n_taken !== k; c++) @(posedge clk);
      #1 `CHK(n_taken, k, "no vector taken")
      `CHK(taken_vec, vec, "vector taken")
      `CHK(taken_high, hi, "level taken")
   endtask
   task automatic give_back;
      @(posedge clk) do_ret <= 1'b1;
      @(posedge clk) do_ret <= 1'b0;
   endtask
   task automatic quiet;
      repeat (6) begin
         @(posedge clk);
         #1 `CHK(irq_request, 1'b0, "request while served")
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test;
   end
   initial begin
      {rstn, sfr_wr, sfr_rd, dma_service, en, do_ret, sfr_addr, sfr_wdata} = '0;
      {f, leg, dmad, dly, k} = '0;
      s = 32'h047E62BD;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(ra[i], d);
         `CHK(d, 8'h00, "reset value")
         for (int j = 0; j < 2; j++) begin
            s = lfsr(s);
            v = j ? s[7:0] : 8'hFF;
            wr(ra[i], v);
            rd(ra[i], d);
            `CHK(d, v & rm[i], "readback")
         end
      end
      wr(8'hC9, 8'hFF);
      rd(8'hC9, d);
      `CHK(d, 8'h00, "unmapped read")
      $display("registers done");
      for (int n = 0; n < 150; n++) begin
         s = lfsr(s);
         @(posedge clk) begin
            f <= s[10:0] & s[21:11];
            leg <= s[26:22];
            dmad <= s[28:27];
            dma_service <= s[29];
         end
         ga = s[30] | s[31];
         s = lfsr(s);
         m = s[10:0];
         p = s[21:11];
         set_regs(ga, m, p);
         repeat (4) @(posedge clk);
         #1 e = pick(raw_src(dma_service, f, leg, dmad) & m & {11{ga}}, p);
         `CHK(irq_request, e[5], "request")
         if (e[5]) begin
            `CHK(irq_vector, vt[e[3:0]], "vector")
            `CHK(irq_level_high, e[4], "level")
         end
      end
      $display("random sources done");
      @(posedge clk) begin
         {dma_service, leg, dmad, f} <= {1'b0, 5'h1F, 2'h3, 11'h229};
      end
      m = 11'h7FF;
      set_regs(1'b1, m, 11'h000);
      // CPU takes vectors only once enables and priorities are in place
      en <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         take(vt[i], 1'b0);
         m[i] = 1'b0;
         set_regs(1'b1, m, 11'h000);
         give_back;
      end
      $display("polling order done");
      dly <= 2'h3;
      set_regs(1'b1, 11'h7FF, 11'h400);
      take(8'h23, 1'b1);
      quiet;
      set_regs(1'b1, 11'h3FF, 11'h400);
      give_back;
      take(8'h03, 1'b0);
      set_regs(1'b1, 11'h3FF, 11'h402);
      take(8'h2B, 1'b1);
      quiet;
      $display("preemption done");
      stop_test;
   end
endmodule
